// ===== wcl_wiper_loader.sv
// Serial wiper code loader: shift register, wiper latch, open-drain chain output
// Functional notes
// - Chip select low: every rising serial clock shifts the data input in, unless midscale reset is low.
// - Chip select rising copies the shift register into the wiper latch.
// - Overlong frames keep only the last seven bits received.
// - Chip select low enables shifting and the serial output driver.
// - Each shift presents the bit that entered seven clocks earlier.
// - Serial output only pulls low; an external pull-up gives the high.
// - Midscale reset low holds latch at midscale and clears output latch.
// - Midscale reset rising with chip select high leaves latch at 0x40.
// - No wiper code is promised before a reset or write.
// - Shutdown opens terminal A, shorts wiper to B, disables serial output.
// - Leaving shutdown applies the code held in the latch.
// - Writes are accepted and latched during shutdown.
`timescale 1ns/100ps
`include "wcl_map.svh"

module wcl_wiper_loader (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // Serial link pins
    input  wire logic                      cs_n,
    input  wire logic                      sclk,
    input  wire logic                      sdi,
    output logic                           sdo_data,
    output logic                           sdo_oe,
    // Control pins
    input  wire logic                      midscale_reset_n,
    input  wire logic                      shutdown_n,
    // Analog switch control
    output wcl_pkg::wcl_code_t             wiper_code,
    output logic                           wiper_code_valid,
    output logic                           terminal_a_switch,
    output logic                           wiper_b_short,
    output logic                           shutdown_active,
    // Frame status
    output logic                           frame_active,
    output logic [`WCL_CNT_W-1:0]          frame_bit_count,
    output logic                           frame_overlong
);

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    wcl_pin_if pins ();

    wcl_pin_cond u_pin_cond (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .cs_n             (cs_n),
        .sclk             (sclk),
        .sdi              (sdi),
        .midscale_reset_n (midscale_reset_n),
        .shutdown_n       (shutdown_n),
        .pins             (pins.cond)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Shift one bit in at the bottom; the top bit falls out
    function automatic wcl_pkg::wcl_code_t shift_in(input wcl_pkg::wcl_code_t cur, input logic bit_in);
        shift_in = {cur[`WCL_CODE_W-2:0], bit_in};
    endfunction

    // Saturating bit counter
    function automatic logic [`WCL_CNT_W-1:0] count_up(input logic [`WCL_CNT_W-1:0] cur);
        if (cur == `WCL_CNT_MAX) begin
            count_up = cur;
        end else begin
            count_up = cur + 8'h01;
        end
    endfunction

    // Open-drain enable: pull low only for a zero, and only while the driver is on
    function automatic logic pull_low(input logic drive_on, input logic bit_out);
        pull_low = drive_on & ~bit_out;
    endfunction

    // ****************************************************************
    // Decoded conditions
    // ****************************************************************
    logic selected;
    logic mid_hold;
    logic in_shutdown_n;
    logic shift_now;

    assign mid_hold  = ~pins.mrst_n_lvl;
    assign in_shutdown_n   = ~pins.shutdown_n_n_lvl;
    // Shifting continues in shutdown so a preset can be written
    assign selected  = ~pins.cs_n_lvl;
    assign shift_now = selected & pins.sclk_rise;

    // ****************************************************************
    // Load strobes
    // ****************************************************************
    // Midscale reset outranks both strobes in the latch, so neither is gated with mid_hold here
    logic load_now;
    logic preset_now;

    // A load needs the chip select edge only; shutdown does not block it
    assign load_now   = pins.cs_rise;
    // A preset edge counts only while the host is not selecting the part
    assign preset_now = pins.mrst_rise & ~selected;

    // ****************************************************************
    // State
    // ****************************************************************
    // Frame sequencing
    wcl_pkg::wcl_frame_e   state_q;
    wcl_pkg::wcl_frame_e   state_d;
    logic                  act_q;
    logic                  act_d;

    // Serial path
    wcl_pkg::wcl_code_t    sreg_q;
    wcl_pkg::wcl_code_t    sreg_d;
    logic                  sdo_q;
    logic                  sdo_d;
    logic                  oe_q;
    logic                  oe_d;

    // Wiper latch
    wcl_pkg::wcl_code_t    latch_q;
    wcl_pkg::wcl_code_t    latch_d;
    logic                  valid_q;
    logic                  valid_d;

    // Frame counter
    logic [`WCL_CNT_W-1:0] cnt_q;
    logic [`WCL_CNT_W-1:0] cnt_d;
    logic                  ovl_q;
    logic                  ovl_d;

    // ****************************************************************
    // Frame sequencing
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        if (rst) begin
            state_d = wcl_pkg::WCL_ST_IDLE;
        end else begin
            case (state_q)
                wcl_pkg::WCL_ST_IDLE: begin
                    if (mid_hold) begin
                        state_d = wcl_pkg::WCL_ST_MID;
                    end else if (selected) begin
                        state_d = wcl_pkg::WCL_ST_SHIFT;
                    end
                end
                wcl_pkg::WCL_ST_SHIFT: begin
                    if (mid_hold) begin
                        state_d = wcl_pkg::WCL_ST_MID;
                    end else if (pins.cs_rise) begin
                        state_d = wcl_pkg::WCL_ST_IDLE;
                    end
                end
                wcl_pkg::WCL_ST_MID: begin
                    if (!mid_hold) begin
                        state_d = selected ? wcl_pkg::WCL_ST_SHIFT : wcl_pkg::WCL_ST_IDLE;
                    end
                end
                default: begin
                    state_d = wcl_pkg::WCL_ST_IDLE;
                end
            endcase
        end
        // Registered so the status pin comes straight from a flop
        act_d = (state_d == wcl_pkg::WCL_ST_SHIFT);
    end

    always_ff @(posedge ref_clk) begin
        state_q <= state_d;
        act_q   <= act_d;
    end

    // ****************************************************************
    // Shift register and chain output latch
    // ****************************************************************
    always_comb begin
        sreg_d = sreg_q;
        sdo_d  = sdo_q;
        if (rst) begin
            sreg_d = `WCL_CODE_RST;
            sdo_d  = `WCL_SDO_CLEAR;
        end else if (mid_hold) begin
            // Shift register itself is left alone; only the output latch clears
            sdo_d  = `WCL_SDO_CLEAR;
        end else if (shift_now) begin
            sreg_d = shift_in(sreg_q, pins.sdi_lvl);
            sdo_d  = sreg_q[`WCL_CODE_W-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        sreg_q <= sreg_d;
        sdo_q  <= sdo_d;
    end

    // ****************************************************************
    // Frame bit counter
    // ****************************************************************
    // Cleared on every chip select rise, even one cut by midscale reset,
    // so a stale count never lingers while the part is deselected
    always_comb begin
        cnt_d = cnt_q;
        ovl_d = ovl_q;
        if (rst) begin
            cnt_d = 8'h00;
            ovl_d = 1'h0;
        end else if (pins.cs_rise) begin
            ovl_d = (cnt_q > `WCL_CODE_BITS);
            cnt_d = 8'h00;
        end else if (shift_now && !mid_hold) begin
            cnt_d = count_up(cnt_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        cnt_q <= cnt_d;
        ovl_q <= ovl_d;
    end

    // ****************************************************************
    // Open-drain driver enable
    // ****************************************************************
    // Only a low is ever driven, so a chain of outputs can share pull-ups safely
    always_comb begin
        oe_d = 1'h0;
        if (!rst) begin
            oe_d = pull_low(selected && !in_shutdown_n, sdo_d);
        end
    end

    always_ff @(posedge ref_clk) begin
        oe_q <= oe_d;
    end

    // ****************************************************************
    // Wiper code latch
    // ****************************************************************
    // After the block reset the code is cleared to 0x00 and flagged not valid
    always_comb begin
        latch_d = latch_q;
        valid_d = valid_q;
        if (rst) begin
            latch_d = `WCL_CODE_RST;
            valid_d = 1'h0;
        end else if (mid_hold) begin
            latch_d = `WCL_MIDSCALE;
            valid_d = 1'h1;
        end else if (preset_now) begin
            latch_d = `WCL_MIDSCALE;
            valid_d = 1'h1;
        end else if (load_now) begin
            // Load goes ahead in shutdown as well, so a preset survives it
            latch_d = sreg_q;
            valid_d = 1'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        latch_q <= latch_d;
        valid_q <= valid_d;
    end

    // ****************************************************************
    // Switch control and status
    // ****************************************************************
    logic tas_q;
    logic tas_d;
    logic wbs_q;
    logic wbs_d;

    always_comb begin
        if (rst) begin
            tas_d = 1'h0;
            wbs_d = 1'h0;
        end else begin
            tas_d = ~in_shutdown_n;
            wbs_d = in_shutdown_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        tas_q <= tas_d;
        wbs_q <= wbs_d;
    end

    // Latch is presented unchanged through shutdown, so release restores it
    assign wiper_code        = latch_q;
    assign wiper_code_valid  = valid_q;
    assign terminal_a_switch = tas_q;
    assign wiper_b_short     = wbs_q;
    assign shutdown_active   = wbs_q;
    assign frame_active      = act_q;
    assign frame_bit_count   = cnt_q;
    assign frame_overlong    = ovl_q;
    assign sdo_data          = 1'h0;
    assign sdo_oe            = oe_q;

endmodule

// ===== wcl_map.svh
// Constants for the serial wiper code loader: widths, values and pin sampling bits
`ifndef WCL_MAP_SVH
`define WCL_MAP_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define WCL_CODE_W        7
`define WCL_CNT_W         8
`define WCL_STATE_W       2

// ****************************************************************
// Values
// ****************************************************************
`define WCL_MIDSCALE      7'h40
`define WCL_CODE_RST      7'h00
`define WCL_CNT_MAX       8'hFF
`define WCL_CODE_BITS     8'h07
`define WCL_SDO_CLEAR     1'h0

// ****************************************************************
// Pin sampling
// ****************************************************************
`define WCL_PIN_N         5
`define WCL_PIN_CS_N      0
`define WCL_PIN_SCLK      1
`define WCL_PIN_SDI       2
`define WCL_PIN_MRST_N    3
`define WCL_PIN_SHUTDOWN_N_N    4
`define WCL_PIN_IDLE      5'h19

`endif

// ===== wcl_pkg.sv
// Types shared by the serial wiper code loader modules
package wcl_pkg;

    // ****************************************************************
    // Frame state
    // ****************************************************************
    typedef enum logic [1:0] {
        WCL_ST_IDLE  = 2'b00,
        WCL_ST_SHIFT = 2'b01,
        WCL_ST_MID   = 2'b10
    } wcl_frame_e;

    typedef logic [6:0] wcl_code_t;

endpackage

// ===== wcl_pin_if.sv
// Conditioned pin levels and edge pulses passed from the sampler to the core
`timescale 1ns/100ps

interface wcl_pin_if;
    logic cs_n_lvl;
    logic cs_rise;
    logic sclk_rise;
    logic sdi_lvl;
    logic mrst_n_lvl;
    logic mrst_rise;
    logic shutdown_n_n_lvl;

    modport cond (
        output cs_n_lvl,
        output cs_rise,
        output sclk_rise,
        output sdi_lvl,
        output mrst_n_lvl,
        output mrst_rise,
        output shutdown_n_n_lvl
    );

    modport core (
        input  cs_n_lvl,
        input  cs_rise,
        input  sclk_rise,
        input  sdi_lvl,
        input  mrst_n_lvl,
        input  mrst_rise,
        input  shutdown_n_n_lvl
    );
endinterface

// ===== wcl_pin_cond.sv
// Two-flop synchronisers and edge detectors for the serial and control pins
`timescale 1ns/100ps
`include "wcl_map.svh"

module wcl_pin_cond (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Raw pins
    input  wire logic               cs_n,
    input  wire logic               sclk,
    input  wire logic               sdi,
    input  wire logic               midscale_reset_n,
    input  wire logic               shutdown_n,
    // Conditioned side
    wcl_pin_if.cond                 pins
);

    // ****************************************************************
    // Synchroniser chain
    // ****************************************************************
    // Stage one feeds stage two only; edges compare stage two with stage three
    logic [`WCL_PIN_N-1:0] meta_q;
    logic [`WCL_PIN_N-1:0] meta_d;
    logic [`WCL_PIN_N-1:0] sync_q;
    logic [`WCL_PIN_N-1:0] sync_d;
    logic [`WCL_PIN_N-1:0] prev_q;
    logic [`WCL_PIN_N-1:0] prev_d;

    always_comb begin
        if (rst) begin
            meta_d = `WCL_PIN_IDLE;
            sync_d = `WCL_PIN_IDLE;
            prev_d = `WCL_PIN_IDLE;
        end else begin
            meta_d = {shutdown_n, midscale_reset_n, sdi, sclk, cs_n};
            sync_d = meta_q;
            prev_d = sync_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
        prev_q <= prev_d;
    end

    // ****************************************************************
    // Levels and edges
    // ****************************************************************
    assign pins.cs_n_lvl   = sync_q[`WCL_PIN_CS_N];
    assign pins.cs_rise    = sync_q[`WCL_PIN_CS_N] & ~prev_q[`WCL_PIN_CS_N];
    // Data is taken with the same delay as the clock so the edge sees the right bit
    assign pins.sclk_rise  = sync_q[`WCL_PIN_SCLK] & ~prev_q[`WCL_PIN_SCLK];
    assign pins.sdi_lvl    = sync_q[`WCL_PIN_SDI];
    assign pins.mrst_n_lvl = sync_q[`WCL_PIN_MRST_N];
    assign pins.mrst_rise  = sync_q[`WCL_PIN_MRST_N] & ~prev_q[`WCL_PIN_MRST_N];
    assign pins.shutdown_n_n_lvl = sync_q[`WCL_PIN_SHUTDOWN_N_N];

endmodule

// ===== wcl_wiper_loader_asserts.sv
// Port checker for the serial wiper code loader
`timescale 1ns/100ps
`include "wcl_map.svh"

module wcl_wiper_loader_asserts (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // Serial link pins
    input wire logic                  cs_n,
    input wire logic                  sclk,
    input wire logic                  sdi,
    input wire logic                  sdo_data,
    input wire logic                  sdo_oe,
    // Control pins
    input wire logic                  midscale_reset_n,
    input wire logic                  shutdown_n,
    // Analog switch control
    input wire wcl_pkg::wcl_code_t    wiper_code,
    input wire logic                  wiper_code_valid,
    input wire logic                  terminal_a_switch,
    input wire logic                  wiper_b_short,
    input wire logic                  shutdown_active,
    // Frame status
    input wire logic                  frame_active,
    input wire logic [`WCL_CNT_W-1:0] frame_bit_count,
    input wire logic                  frame_overlong
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ********
    // Assertions
    // ********
    // Windows allow for the pin synchronisers plus one register stage
    AST_SDO_PULL_LOW_ONLY: assert property (sdo_data == 1'h0)
        else $error("serial output drove high");
    AST_SDO_OFF_DESELECT: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("serial output driven while deselected");
    AST_IDLE_NO_SHIFT: assert property (cs_n [*6] |-> frame_bit_count == 8'h00 && !frame_active)
        else $error("shift activity while deselected");
    AST_COUNT_STEP: assert property (!$stable(frame_bit_count) |->
        frame_bit_count == $past(frame_bit_count) + 8'h01 || frame_bit_count == 8'h00)
        else $error("bit count jumped");
    AST_SHIFT_NEEDS_SCLK: assert property (frame_bit_count > $past(frame_bit_count) |-> $past(sclk, 2))
        else $error("shift without serial clock");
    AST_LATCH_STABLE: assert property ((cs_n && midscale_reset_n) [*8] |-> $stable(wiper_code))
        else $error("latch changed without load");
    AST_MID_HOLD: assert property (!midscale_reset_n [*6] |-> wiper_code == 7'h40 && wiper_code_valid)
        else $error("latch not held at midscale");
    AST_SHUTDOWN_N_ON: assert property (!shutdown_n [*6] |->
        wiper_b_short && shutdown_active && !terminal_a_switch && !sdo_oe)
        else $error("shutdown outputs wrong");
    AST_SHUTDOWN_N_OFF: assert property (shutdown_n [*6] |-> terminal_a_switch && !wiper_b_short)
        else $error("terminal A not restored");

    cover property ($rose(wiper_code_valid));
    cover property ($rose(frame_overlong));
    cover property ($rose(wiper_b_short));
    cover property (frame_bit_count == 8'h0E);
endmodule

bind wcl_wiper_loader wcl_wiper_loader_asserts i_chk (.ref_clk, .rst, .cs_n, .sclk, .sdi, .sdo_data, .sdo_oe,
    .midscale_reset_n, .shutdown_n, .wiper_code, .wiper_code_valid, .terminal_a_switch, .wiper_b_short,
    .shutdown_active, .frame_active, .frame_bit_count, .frame_overlong);

// ===== wcl_host_model.sv
// Serial master model that frames words onto the loader link pins
`timescale 1ns/100ps

module wcl_host_model #(
    parameter int HALF = 16
) (
    // Clock
    input wire logic ref_clk,
    // Link pins
    output logic     cs_n,
    output logic     sclk,
    output logic     sdi,
    input wire logic sdo_line
);
    initial begin
        cs_n = 1'h1;
        sclk = 1'h0;
        sdi  = 1'h0;
    end

    // HALF sets the serial period; chains may need it longer for slow pull-up edges
    task automatic send(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(negedge ref_clk);
        cs_n = 1'h0;
        repeat (4) @(negedge ref_clk);
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            repeat (HALF) @(negedge ref_clk);
            sclk = 1'h1;
            repeat (HALF) @(negedge ref_clk);
            r = {r[14:0], sdo_line};
            sclk = 1'h0;
        end
        repeat (4) @(negedge ref_clk);
        cs_n = 1'h1;
        // Released data line must not keep showing the last bit
        sdi = ~sdi;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// ===== tb_serial_wiper_code_loader.sv
// Self-checking bench for the serial wiper code loader
`timescale 1ns/100ps
`include "wcl_map.svh"

module tb_serial_wiper_code_loader;
    logic                   ref_clk;
    logic                   rst;
    logic                   cs_n;
    logic                   sclk;
    logic                   sdi;
    logic                   sdo_data;
    logic                   sdo_oe;
    logic                   sdo_line;
    logic                   midscale_reset_n;
    logic                   shutdown_n;
    wcl_pkg::wcl_code_t     wiper_code;
    logic                   wiper_code_valid;
    logic                   terminal_a_switch;
    logic                   wiper_b_short;
    logic                   shutdown_active;
    logic                   frame_active;
    logic [`WCL_CNT_W-1:0]  frame_bit_count;
    logic                   frame_overlong;
    logic [15:0]            rx;
    int                     n_mismatch = 0;
    int                     checked = 0;

    // Open-drain line with pull-up
    assign sdo_line = sdo_oe ? sdo_data : 1'h1;

    wcl_wiper_loader i_dut (.ref_clk, .rst, .cs_n, .sclk, .sdi, .sdo_data, .sdo_oe, .midscale_reset_n,
        .shutdown_n, .wiper_code, .wiper_code_valid, .terminal_a_switch, .wiper_b_short,
        .shutdown_active, .frame_active, .frame_bit_count, .frame_overlong);

    wcl_host_model i_host (.ref_clk, .cs_n, .sclk, .sdi, .sdo_line);

    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ********
    // Helpers
    // ********
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        rst = 1'h1;
        cyc(2);
        rst = 1'h0;
        cyc(4);
        chk(wiper_code_valid, 16'h0000);
        chk(sdo_oe, 16'h0000);
        chk(terminal_a_switch, 16'h0001);
    endtask

    task automatic t_load;
        i_host.send(16'h002B, 7, rx);
        chk(rx, 16'h0000);
        chk(wiper_code, 16'h002B);
        chk(wiper_code_valid, 16'h0001);
        chk(frame_overlong, 16'h0000);
    endtask

    task automatic t_overlong;
        i_host.send(16'h03A5, 10, rx);
        chk(rx, 16'h015F);
        chk(wiper_code, 16'h0025);
        chk(frame_overlong, 16'h0001);
    endtask

    // Two-device chain: old register contents come out first
    task automatic t_chain;
        i_host.send({2'h0, 7'h11, 7'h6C}, 14, rx);
        chk(rx, {2'h0, 7'h25, 7'h11});
        chk(wiper_code, 16'h006C);
        chk(frame_overlong, 16'h0001);
        chk(frame_bit_count, 16'h0000);
        chk(frame_active, 16'h0000);
    endtask

    task automatic t_midscale;
        midscale_reset_n = 1'h0;
        cyc(8);
        chk(wiper_code, 16'h0040);
        i_host.send(16'h000F, 7, rx);
        chk(rx, 16'h0000);
        chk(wiper_code, 16'h0040);
        midscale_reset_n = 1'h1;
        cyc(8);
        chk(wiper_code, 16'h0040);
    endtask

    task automatic t_shutdown;
        shutdown_n = 1'h0;
        cyc(6);
        chk(wiper_b_short, 16'h0001);
        chk(terminal_a_switch, 16'h0000);
        chk(shutdown_active, 16'h0001);
        i_host.send(16'h0055, 7, rx);
        chk(rx, 16'h007F);
        chk(wiper_code, 16'h0055);
        shutdown_n = 1'h1;
        cyc(6);
        chk(terminal_a_switch, 16'h0001);
        chk(wiper_code, 16'h0055);
    endtask

    initial begin
        rst = 1'h1;
        midscale_reset_n = 1'h1;
        shutdown_n = 1'h1;
        t_reset;
        t_load;
        t_overlong;
        t_chain;
        t_midscale;
        t_shutdown;
        summarize;
    end

    // Whole run is near 8 us; a hang ends well past that
    initial begin
        #100000;
        n_mismatch++;
        summarize;
    end
endmodule
